// *** aeqc_top.sv ***
// Summary of operation
// RULE1: upper filter limit is bits 7:4, reset 0xA, codes 0-14, centre 7.
// RULE2: lower filter limit is bits 3:0, reset 0x7, codes 0-14, centre 7.
// RULE3: sample filter setting stays between lower and upper limits always; the output resets to 0 and clamps one cycle after the limits change.
// RULE4: software keeps upper limit at or above lower limit.
// RULE5: software should write 0xA9 to the limits at initialisation.
// RULE6: software should use lower limit 0x9 in typical operation.
// RULE7: error select bits 6:4, reset 0x7: clock, encoding, parity errors.
// RULE8: selected errors are counted over half the relock period.
// RULE9: count above threshold steps to a higher equalizer setting; code takes the next candidate, the filter first when loop bit is 1.
// RULE10: in two-step mode selected errors also judge candidate settings.
// RULE11: two-step off: wait full period, accept on current lock.
// RULE12: two-step on: wait half, any error next half advances at once; the code advances only on errors enabled by the error select.
// RULE13: loop bit 0: equalizer inner loop; 1: sample filter inner loop.
// RULE14: bit 0, reset 1, lets sample filter adaptation take part.
// RULE15: threshold is 8 bits, reset 0x1, software never writes zero.
// RULE16: capability bit 4 gates the encoder crc error flag.
// RULE17: software must also clear the separate encoder crc disable bit.
// RULE18: capability register is per port, steered by port selection.
// RULE19: addresses 0x44 to 0x49 are read-only and read zero.
// RULE20: reads come from one selected port, writes go to all enabled.
// RULE21: all waits derive from the relock period input.
// RULE22: error count saturates and clears at every window start.
`timescale 1ns/1ps
module aeqc_top
  import aeqc_pkg::*;
(
  // clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     rstn,
  // register access
  input  wire aeqc_reg_req_t            reg_req,
  output logic                    [7:0] reg_rdata,
  // port paging from the port-select register
  input  wire logic                     read_port_sel,
  input  wire logic               [1:0] write_port_en,
  // relock period in clock cycles
  input  wire logic [AEQC_RELOCK_W-1:0] relock_period,
  // link status from the receiver front end
  input  wire logic                     link_lock_pin,
  input  wire aeqc_err_t                link_err_pin,
  input  wire logic               [1:0] crc_err_event,
  // equalizer controls and status
  output logic                    [3:0] eq_setting,
  output logic                    [3:0] sample_filter,
  output logic                          adapt_locked,
  output logic                    [1:0] crc_error_flag
);

  logic [7:0]  sample_filter_limits;
  logic [7:0]  equalizer_control_one;
  logic [7:0]  adapt_error_limit;
  logic [7:0]  cap_val [AEQC_NUM_PORTS];
  logic [3:0]  lim_up;
  logic [3:0]  lim_lo;
  logic [2:0]  adapt_error_select;
  logic        two_step_validate;
  logic        loop_order_select;
  logic        filter_adapt_allow;
  logic [3:0]  sync1;
  logic [3:0]  sync2;
  logic [3:0]  sync3;
  logic [3:0]  link_filt;
  logic [2:0]  err_prev;
  logic        err_pulse;
  logic        lock_now;
  aeqc_state_t state;
  aeqc_state_t next_state;
  logic [AEQC_RELOCK_W-1:0] cnt;
  logic [AEQC_RELOCK_W-1:0] full_len;
  logic [AEQC_RELOCK_W-1:0] half_len;
  logic [AEQC_RELOCK_W-1:0] cur_len;
  logic        win_done;
  logic        advance;
  logic [7:0]  err_cnt;
  logic [3:0]  eq_code;
  logic [3:0]  sf_code;
  logic [3:0]  next_eq;
  logic [3:0]  next_sf;
  logic        hit_sfl;
  logic        hit_ctl1;
  logic        hit_thr;
  logic        hit_cap;

  // field views
  assign lim_up             = sample_filter_limits[AEQC_SF_UPPER_LSB+:4];
  assign lim_lo             = sample_filter_limits[AEQC_SF_LOWER_LSB+:4];
  assign adapt_error_select = equalizer_control_one[AEQC_ERRSEL_LSB+:3];
  assign two_step_validate  = equalizer_control_one[AEQC_TWO_STEP_BIT];
  assign loop_order_select  = equalizer_control_one[AEQC_LOOP_BIT];
  assign filter_adapt_allow = equalizer_control_one[AEQC_FADAPT_BIT];

  // address decode
  assign hit_sfl  = (reg_req.addr == AEQC_SFL_ADDR);
  assign hit_ctl1 = (reg_req.addr == AEQC_CTL1_ADDR);
  assign hit_thr  = (reg_req.addr == AEQC_THR_ADDR);
  assign hit_cap  = (reg_req.addr == AEQC_CAP_ADDR);

  // shared registers
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      sample_filter_limits  <= AEQC_SFL_RST;  // [RULE1] [RULE2]
      equalizer_control_one <= AEQC_CTL1_RST; // [RULE7] [RULE11] [RULE14]
      adapt_error_limit     <= AEQC_THR_RST;  // [RULE15]
    end
    else if (reg_req.wr)
    begin
      if (hit_sfl)
        sample_filter_limits <= reg_req.wdata;
      if (hit_ctl1)
        equalizer_control_one <= {1'b0, reg_req.wdata[6:0]};
      if (hit_thr)
        adapt_error_limit <= reg_req.wdata;
    end
  end

  // per-port capability registers, broadcast writes
  genvar p;
  generate
    for (p = 0; p < AEQC_NUM_PORTS; p++)
    begin : g_port
      aeqc_port_cap u_cap (
        .core_clk   (core_clk),
        .rstn       (rstn),
        .wr_en      (reg_req.wr & hit_cap & write_port_en[p]), // [RULE20]
        .wdata      (reg_req.wdata),
        .cap        (cap_val[p]),
        .crc_err_in (crc_err_event[p]),
        .crc_flag   (crc_error_flag[p])
      );
    end
  endgenerate

  // registered read data, unmapped and reserved read zero
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      reg_rdata <= 8'h00;
    else if (reg_req.rd)
    begin
      if (hit_sfl)
        reg_rdata <= sample_filter_limits;
      else if (hit_ctl1)
        reg_rdata <= equalizer_control_one;
      else if (hit_thr)
        reg_rdata <= adapt_error_limit;
      else if (hit_cap)
        reg_rdata <= cap_val[read_port_sel]; // [RULE18] [RULE20]
      else
        reg_rdata <= 8'h00; // [RULE19]
    end
  end

  // three-stage synchroniser, change accepted when stages two and three agree
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      sync1     <= 4'h0;
      sync2     <= 4'h0;
      sync3     <= 4'h0;
      link_filt <= 4'h0;
    end
    else
    begin
      sync1 <= {link_lock_pin, link_err_pin};
      sync2 <= sync1;
      sync3 <= sync2;
      for (int i = 0; i < 4; i++)
        if (sync2[i] == sync3[i])
          link_filt[i] <= sync3[i];
    end
  end

  // error rising edges, gated by the error select
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      err_prev <= 3'h0;
    else
      err_prev <= link_filt[2:0];
  end

  assign lock_now  = link_filt[3];
  assign err_pulse = |(link_filt[2:0] & ~err_prev & adapt_error_select); // [RULE7]

  // window lengths from the relock period
  always_comb
  begin
    full_len = (relock_period == '0) ? 16'h0001 : relock_period; // [RULE21]
    half_len = (relock_period[15:1] == '0) ? 16'h0001
             : {1'b0, relock_period[15:1]}; // [RULE8] [RULE21]
    if (state == ST_SETTLE && !two_step_validate)
      cur_len = full_len; // [RULE11]
    else
      cur_len = half_len; // [RULE12]
  end

  assign win_done = (cnt >= cur_len - 16'h0001);

  // next candidate setting in loop order
  always_comb
  begin
    next_eq = eq_code;
    next_sf = sf_code;
    if (!filter_adapt_allow)
      next_eq = (eq_code == AEQC_EQ_CODE_MAX) ? 4'h0 : eq_code + 4'h1; // [RULE14]
    else if (!loop_order_select)
    begin
      if (eq_code != AEQC_EQ_CODE_MAX)
        next_eq = eq_code + 4'h1; // [RULE13]
      else
      begin
        next_eq = 4'h0;
        next_sf = (sf_code >= lim_up) ? lim_lo : sf_code + 4'h1;
      end
    end
    else
    begin
      if (sf_code < lim_up)
        next_sf = sf_code + 4'h1; // [RULE13]
      else
      begin
        next_sf = lim_lo;
        next_eq = (eq_code == AEQC_EQ_CODE_MAX) ? 4'h0 : eq_code + 4'h1;
      end
    end
  end

  // state transitions
  always_comb
  begin
    next_state = state;
    advance    = 1'b0;
    case (state)
      ST_START:
        next_state = ST_SETTLE;
      ST_SETTLE:
        if (win_done)
        begin
          if (two_step_validate)
            next_state = ST_VERIFY; // [RULE12]
          else if (lock_now)
            next_state = ST_TRACK; // [RULE11]
          else
            advance = 1'b1;
        end
      ST_VERIFY:
        if (err_pulse)
        begin
          advance    = 1'b1; // [RULE10] [RULE12]
          next_state = ST_SETTLE;
        end
        else if (win_done)
        begin
          if (lock_now)
            next_state = ST_TRACK;
          else
          begin
            advance    = 1'b1;
            next_state = ST_SETTLE;
          end
        end
      ST_TRACK:
        if (!lock_now || (win_done && err_cnt > adapt_error_limit))
        begin
          advance    = 1'b1; // [RULE9]
          next_state = ST_SETTLE;
        end
      default:
        next_state = ST_START;
    endcase
  end

  // state register and window counter
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      state <= ST_START;
      cnt   <= '0;
    end
    else
    begin
      state <= next_state;
      if (next_state != state || advance || win_done)
        cnt <= '0;
      else
        cnt <= cnt + 16'h0001;
    end
  end

  // saturating error accumulator, cleared at each window start
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      err_cnt <= 8'h00;
    else if (state != ST_TRACK || win_done)
      err_cnt <= 8'h00; // [RULE22]
    else if (err_pulse && err_cnt != 8'hFF)
      err_cnt <= err_cnt + 8'h01; // [RULE8] [RULE22]
  end

  // candidate equalizer and filter codes
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      eq_code <= 4'h0;
      sf_code <= 4'h0;
    end
    else if (state == ST_START)
    begin
      eq_code <= 4'h0;
      sf_code <= lim_lo;
    end
    else if (advance)
    begin
      eq_code <= next_eq;
      sf_code <= next_sf;
    end
  end

  // outputs, filter clamped into its limits
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      eq_setting    <= 4'h0;
      sample_filter <= 4'h0;
      adapt_locked  <= 1'b0;
    end
    else
    begin
      eq_setting   <= eq_code;
      adapt_locked <= (state == ST_TRACK);
      if (sf_code < lim_lo)
        sample_filter <= lim_lo; // [RULE3]
      else if (sf_code > lim_up)
        sample_filter <= lim_up; // [RULE3]
      else
        sample_filter <= sf_code;
    end
  end

  sequence settle_end_s;
    state == ST_SETTLE && win_done;
  endsequence

  sequence track_over_s;
    state == ST_TRACK && lock_now && win_done && err_cnt > adapt_error_limit;
  endsequence

  sf_clamp_a: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE3]
    (lim_up >= lim_lo) |=> (sample_filter <= $past(lim_up)
                            && sample_filter >= $past(lim_lo)))
    else $error("sample filter outside limits");

  rsv_read_a: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE19]
    (reg_req.rd && reg_req.addr >= AEQC_RSV_LO_ADDR
     && reg_req.addr <= AEQC_RSV_HI_ADDR) |=> (reg_rdata == 8'h00))
    else $error("reserved address read nonzero");

  two_step_a: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE12]
    (settle_end_s ##0 two_step_validate) |=> (state == ST_VERIFY))
    else $error("two-step did not enter verify");

  one_step_a: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE11]
    (settle_end_s ##0 (!two_step_validate && lock_now)) |=> (state == ST_TRACK))
    else $error("locked setting not accepted");

  verify_err_a: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE10]
    (state == ST_VERIFY && err_pulse) |=> (state == ST_SETTLE
      && {eq_code, sf_code} == $past({next_eq, next_sf})))
    else $error("verify error did not advance");

  thr_step_a: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE9]
    track_over_s |=> (state == ST_SETTLE) ##1 (eq_setting == $past(eq_code)))
    else $error("threshold excess did not step");

  err_clear_a: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE22]
    (state == ST_TRACK && win_done) |=> (err_cnt == 8'h00))
    else $error("error count not cleared at window");

  err_sat_a: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE22]
    (state == ST_TRACK && !win_done && err_cnt == 8'hFF) |=> (err_cnt != 8'h00
      || $past(state) != ST_TRACK || $past(win_done)))
    else $error("error count wrapped");

  bcast_wr_a: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE20]
    (reg_req.wr && hit_cap && write_port_en == 2'b11)
    |=> (cap_val[0] == $past(reg_req.wdata) && cap_val[1] == $past(reg_req.wdata)))
    else $error("broadcast write missed a port");

  loop_inner_a: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE13]
    (advance && state != ST_START && filter_adapt_allow && !loop_order_select
     && eq_code != AEQC_EQ_CODE_MAX) |=> (eq_code == $past(eq_code) + 4'h1
     && sf_code == $past(sf_code)))
    else $error("equalizer not inner loop");

endmodule // aeqc_top

// *** aeqc_pkg.sv ***
package aeqc_pkg;

  // register offsets in the byte-wide local map
  localparam logic [7:0] AEQC_SFL_ADDR    = 8'h41;
  localparam logic [7:0] AEQC_CTL1_ADDR   = 8'h42;
  localparam logic [7:0] AEQC_THR_ADDR    = 8'h43;
  localparam logic [7:0] AEQC_RSV_LO_ADDR = 8'h44;
  localparam logic [7:0] AEQC_RSV_HI_ADDR = 8'h49;
  localparam logic [7:0] AEQC_CAP_ADDR    = 8'h4A;

  // field positions
  localparam int AEQC_SF_UPPER_LSB = 4;
  localparam int AEQC_SF_LOWER_LSB = 0;
  localparam int AEQC_ERRSEL_LSB   = 4;
  localparam int AEQC_CTL1_RSV_BIT = 7;
  localparam int AEQC_TWO_STEP_BIT = 2;
  localparam int AEQC_LOOP_BIT     = 1;
  localparam int AEQC_FADAPT_BIT   = 0;
  localparam int AEQC_CRC_EN_BIT   = 4;

  // reset values
  localparam logic [7:0] AEQC_SFL_RST  = 8'hA7;
  localparam logic [7:0] AEQC_CTL1_RST = 8'h71;
  localparam logic [7:0] AEQC_THR_RST  = 8'h01;
  localparam logic [7:0] AEQC_CAP_RST  = 8'h00;

  // code ranges and widths
  localparam logic [3:0] AEQC_EQ_CODE_MAX = 4'hF;
  localparam int         AEQC_RELOCK_W    = 16;
  localparam int         AEQC_NUM_PORTS   = 2;

  // adaptation sequencer states
  typedef enum logic [1:0] {
    ST_START  = 2'b00,
    ST_SETTLE = 2'b01,
    ST_VERIFY = 2'b10,
    ST_TRACK  = 2'b11
  } aeqc_state_t;

  // link error indications
  typedef struct packed {
    logic clk_err;
    logic enc_err;
    logic par_err;
  } aeqc_err_t;

  // register access request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } aeqc_reg_req_t;

endpackage

// *** aeqc_port_cap.sv ***
`timescale 1ns/1ps
module aeqc_port_cap
  import aeqc_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // register write
  input  wire logic       wr_en,
  input  wire logic [7:0] wdata,
  output logic      [7:0] cap,
  // crc event and flag
  input  wire logic       crc_err_in,
  output logic            crc_flag
);

  // capability register, all bits writable
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      cap <= AEQC_CAP_RST;
    else if (wr_en)
      cap <= wdata;
  end

  // crc flag passes only while enabled
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      crc_flag <= 1'b0;
    else
      crc_flag <= crc_err_in & cap[AEQC_CRC_EN_BIT]; // [RULE16]
  end

  crc_gate_a: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE16]
    crc_err_in |=> (crc_flag == $past(cap[AEQC_CRC_EN_BIT])))
    else $error("crc flag does not follow enable");

endmodule // aeqc_port_cap

// *** aeqc_serializer_model.sv ***
`timescale 1ns/1ps
module aeqc_serializer_model
  import aeqc_pkg::*;
(
  // clock
  input  wire logic core_clk,
  // commands from the bench
  input  wire logic lock_cmd,
  input  wire logic burst_go,
  input  wire logic stream_on,
  // link status seen by the receiver
  output logic      link_lock_pin,
  output aeqc_err_t link_err_pin
);
  int         left  = 0;
  logic [1:0] phase = 2'b00;
  logic       go;
  logic       lock;
  logic       strm;

  // commands are taken at the edge, the link answers just after it;
  // every error is two cycles high and two low so that the receiver's
  // three-stage filter passes it; a burst gives four errors
  always @(posedge core_clk)
  begin
    go   = burst_go;
    lock = lock_cmd;
    strm = stream_on;
    #1;
    phase = phase + 2'b01;
    if (go)
      left = 16;
    else if (left > 0)
      left = left - 1;
    link_lock_pin = lock;
    if ((left > 0 && left[1]) || (strm && phase[1]))
      link_err_pin = 3'b111;
    else
      link_err_pin = 3'b000;
  end
endmodule // aeqc_serializer_model

// *** adaptive_eq_control_test.sv ***
`timescale 1ns/1ps
module adaptive_eq_control_test;
  import aeqc_pkg::*;
  // one register row: write flag, address, data, expected read
  typedef struct packed {
    logic       w;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } aeqc_row_t;
  localparam aeqc_row_t ROWS [13] = '{
    '{1'b0, 8'h41, 8'h00, 8'hA7},
    '{1'b0, 8'h42, 8'h00, 8'h71},
    '{1'b0, 8'h43, 8'h00, 8'h01},
    '{1'b0, 8'h44, 8'h00, 8'h00},
    '{1'b0, 8'h49, 8'h00, 8'h00},
    '{1'b0, 8'h4A, 8'h00, 8'h00},
    '{1'b1, 8'h41, 8'hA9, 8'hA9},
    '{1'b1, 8'h42, 8'hFF, 8'h7F},
    '{1'b1, 8'h43, 8'h05, 8'h05},
    '{1'b1, 8'h44, 8'hFF, 8'h00},
    '{1'b1, 8'h49, 8'hFF, 8'h00},
    '{1'b1, 8'h50, 8'hFF, 8'h00},
    '{1'b1, 8'h4A, 8'h10, 8'h10}
  };
  // stimulus
  logic                     core_clk;
  logic                     rstn;
  aeqc_reg_req_t            reg_req;
  logic                     read_port_sel;
  logic               [1:0] write_port_en;
  logic [AEQC_RELOCK_W-1:0] relock_period;
  logic               [1:0] crc_err_event;
  logic                     lock_cmd;
  logic                     burst_go;
  logic                     stream_on;
  // observed
  logic               [7:0] reg_rdata;
  logic               [3:0] eq_setting;
  logic               [3:0] sample_filter;
  logic                     adapt_locked;
  logic               [1:0] crc_error_flag;
  logic                     link_lock_pin;
  aeqc_err_t                link_err_pin;
  logic               [3:0] seen;
  int                       num_errors;
  int                       n_tests;
  int                       cycles;

  aeqc_top u_aeqc_top (
    .core_clk       (core_clk),
    .rstn           (rstn),
    .reg_req        (reg_req),
    .reg_rdata      (reg_rdata),
    .read_port_sel  (read_port_sel),
    .write_port_en  (write_port_en),
    .relock_period  (relock_period),
    .link_lock_pin  (link_lock_pin),
    .link_err_pin   (link_err_pin),
    .crc_err_event  (crc_err_event),
    .eq_setting     (eq_setting),
    .sample_filter  (sample_filter),
    .adapt_locked   (adapt_locked),
    .crc_error_flag (crc_error_flag)
  );

  aeqc_serializer_model u_aeqc_serializer_model (
    .core_clk      (core_clk),
    .lock_cmd      (lock_cmd),
    .burst_go      (burst_go),
    .stream_on     (stream_on),
    .link_lock_pin (link_lock_pin),
    .link_err_pin  (link_err_pin)
  );

  // clock
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // hang guard
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      end_sim();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    step(1);
    reg_req.wr    = 1'b1;
    reg_req.addr  = a;
    reg_req.wdata = d;
    step(1);
    reg_req.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    step(1);
    reg_req.rd   = 1'b1;
    reg_req.addr = a;
    step(1);
    reg_req.rd = 1'b0;
    chk(reg_rdata, e);
  endtask

  // wait a bounded time for the lock flag to reach a level
  task automatic wait_lock(input logic want, input int max);
    int i;
    i = 0;
    while (adapt_locked !== want && i < max)
    begin
      step(1);
      i++;
    end
    chk({7'h0, adapt_locked}, {7'h0, want});
  endtask

  // the lock flag must keep one level for n cycles
  task automatic stay_lock(input logic want, input int n);
    int bad;
    bad = 0;
    repeat (n)
    begin
      step(1);
      if (adapt_locked !== want)
        bad++;
    end
    chk(bad[7:0], 8'h00);
  endtask

  task automatic burst();
    step(1);
    burst_go = 1'b1;
    step(1);
    burst_go = 1'b0;
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    num_errors    = 0;
    n_tests       = 0;
    cycles        = 0;
    rstn          = 1'b0;
    reg_req       = '0;
    read_port_sel = 1'b0;
    write_port_en = 2'b11;
    // a burst always puts at least two errors into one of the twelve-cycle half windows
    relock_period = 16'h0018;
    crc_err_event = 2'b00;
    lock_cmd      = 1'b0;
    burst_go      = 1'b0;
    stream_on     = 1'b0;
    step(12);
    chk({eq_setting, sample_filter}, 8'h00);
    chk(reg_rdata, 8'h00);
    chk({5'h0, adapt_locked, crc_error_flag}, 8'h00);
    $display("reset values done");
    rstn = 1'b1;
    for (int r = 0; r < 13; r++)
    begin
      if (ROWS[r].w)
        wr(ROWS[r].a, ROWS[r].d);
      rd(ROWS[r].a, ROWS[r].e);
    end
    $display("register table done");
    // paged capability: write port 0 only, read each port back
    write_port_en = 2'b01;
    wr(8'h4A, 8'h00);
    rd(8'h4A, 8'h00);
    read_port_sel = 1'b1;
    rd(8'h4A, 8'h10);
    write_port_en = 2'b11;
    crc_err_event = 2'b11;
    step(1);
    crc_err_event = 2'b00;
    chk({6'h0, crc_error_flag}, 8'h02);
    $display("paging and crc flag done");
    // fresh start, then a one-step search until lock
    rstn = 1'b0;
    step(2);
    rstn = 1'b1;
    wr(8'h41, 8'hA9);
    step(30);
    chk({7'h0, eq_setting != 4'h0}, 8'h01);
    chk({7'h0, sample_filter inside {4'h9, 4'hA}}, 8'h01);
    lock_cmd = 1'b1;
    wait_lock(1'b1, 40);
    seen = eq_setting;
    burst();
    wait_lock(1'b0, 40);
    chk({4'h0, eq_setting}, {4'h0, seen + 4'h1});
    wait_lock(1'b1, 40);
    $display("one-step adaptation done");
    // errors at or under the limit, or deselected, leave the lock alone
    wr(8'h43, 8'h05);
    burst();
    stay_lock(1'b1, 60);
    wr(8'h43, 8'h01);
    wr(8'h42, 8'h01);
    burst();
    stay_lock(1'b1, 60);
    $display("error limit and select done");
    // two-step: errors while verifying keep the search moving
    wr(8'h42, 8'h75);
    lock_cmd = 1'b0;
    wait_lock(1'b0, 20);
    stream_on = 1'b1;
    lock_cmd  = 1'b1;
    stay_lock(1'b0, 80);
    stream_on = 1'b0;
    wait_lock(1'b1, 40);
    $display("two-step done");
    // filter adaptation barred: filter holds while eq walks
    wr(8'h42, 8'h70);
    lock_cmd = 1'b0;
    step(10);
    seen = sample_filter;
    step(200);
    chk({4'h0, sample_filter}, {4'h0, seen});
    // filter as inner loop: filter moves within a few short periods
    relock_period = 16'h0008;
    wr(8'h42, 8'h73);
    for (int i = 0; i < 30 && sample_filter == seen; i++)
      step(1);
    chk({7'h0, sample_filter != seen}, 8'h01);
    chk({7'h0, sample_filter inside {4'h9, 4'hA}}, 8'h01);
    $display("loop order done");
    end_sim();
  end
endmodule // adaptive_eq_control_test
